// File: pkg/ialu_params.svh
/*
 * constants of the integer execution datapath: widths, field positions,
 * immediate sizes, reset values.
 * assumes it is included by bare name from the package and the rtl files.
 */
// Functional notes
// - add with extra one gives sum plus one
// - subtract with extra one subtracts one more
// - immediates sign-extended to 64 bits before use
// - 15-bit immediate replaces first register operand
// - 22-bit immediate add, source register 0-3
// - shifted add shifts by 1 to 4
// - and, or, xor on register or immediate
// - and-with-inverted complements the other register
// - pointer sum zeroes top, copies region bits
// - shifted pointer sum, two registers only
// - sign/zero widen from 8, 16, 32 bits
// - variable right shifts, signed or zero fill
// - variable left shift by register count
// - field extract, sign or zero upper fill
// - insert field from register or constant immediate
// - merge keeps second source, zeroing clears outside
// - funnel shift slices 128-bit concatenation
// - long immediate load writes full 64 bits
// - general register zero always reads zero
// - compares write boolean outcome to predicates
// - false predicate suppresses register writes and normal compares; unconditional compares still write zeroes
// - predicates single bits, flag zero fixed true
// - unpredicable operations write their register whatever the flag; compares still follow the flag
`ifndef IALU_PARAMS_SVH
`define IALU_PARAMS_SVH

// ***************************************************
// datapath widths
// ***************************************************
`define IALU_XLEN 64
`define IALU_PTR_W 32
`define IALU_REG_IDX_W 7
`define IALU_PRED_IDX_W 6
`define IALU_NPRED 64

// ***************************************************
// immediate sizes
// ***************************************************
`define IALU_IMM8_W 8
`define IALU_IMM15_W 15
`define IALU_IMM22_W 22
`define IALU_ADD22_MAX_SRC 7'h03

// ***************************************************
// pointer region bits and fixed flag
// ***************************************************
`define IALU_REGION_SRC_LO 30
`define IALU_REGION_DST_LO 61
`define IALU_FIXED_TRUE_IDX 6'h00
`define IALU_PRED_RST 1'b0

`endif

// File: pkg/ialu_pkg.sv
/*
 * types of the integer execution datapath: operations, compare relations,
 * widening sizes.
 * assumes the params header is on the include path.
 */
package ialu_pkg;
	`include "ialu_params.svh"

	// operations issued to the unit
	typedef enum logic [4:0] {
		IALU_OP_ADD, IALU_OP_ADD1, IALU_OP_SUB, IALU_OP_SUB1, IALU_OP_ADD22,
		IALU_OP_SHLADD, IALU_OP_AND, IALU_OP_OR, IALU_OP_XOR, IALU_OP_ANDCM,
		IALU_OP_ADDP, IALU_OP_SHLADDP, IALU_OP_SXT, IALU_OP_ZXT, IALU_OP_SHR,
		IALU_OP_SHRU, IALU_OP_SHL, IALU_OP_EXTR, IALU_OP_EXTRU, IALU_OP_DEP,
		IALU_OP_DEPZ, IALU_OP_SHRP, IALU_OP_MOVL, IALU_OP_CMP, IALU_OP_NOP
	} ialu_op_t;

	// compare relations
	typedef enum logic [1:0] {IALU_REL_EQ, IALU_REL_LT, IALU_REL_LTU} ialu_rel_t;

	// widening source sizes
	typedef enum logic [1:0] {IALU_W8, IALU_W16, IALU_W32} ialu_width_t;
endpackage : ialu_pkg

// File: pkg/ialu_pred_if.sv
/*
 * carrier between the datapath and its predicate flag file.
 * assumes both ends share the core clock.
 */
interface ialu_pred_if;
	logic [5:0] qp_idx;
	logic qp_val;
	logic we1;
	logic [5:0] idx1;
	logic val1;
	logic we2;
	logic [5:0] idx2;
	logic val2;
	logic [63:0] flags;

	modport core (output qp_idx, we1, idx1, val1, we2, idx2, val2, input qp_val, flags);
	modport file (input qp_idx, we1, idx1, val1, we2, idx2, val2, output qp_val, flags);
endinterface : ialu_pred_if

// File: rtl/ialu_pred_file.sv
/*
 * predicate flag file: 63 writable one-bit flags plus the fixed true flag.
 * assumes the core issues at most two writes per cycle, one per port, which may name the same flag.
 */
`include "ialu_params.svh"
module ialu_pred_file (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// datapath side
	ialu_pred_if.file pif
);
	import ialu_pkg::*;

	logic [63:1] flag_q;

	// ***************************************************
	// flag storage
	// ***************************************************
	// each writable flag: second port wins on a same-index write
	for (genvar g = 1; g < `IALU_NPRED; g++) begin : g_flag
		always_ff @(posedge i_clk or negedge i_resetn) begin
			if (!i_resetn) begin
				flag_q[g] <= `IALU_PRED_RST;
			end else if (pif.we2 && pif.idx2 == 6'(g)) begin
				flag_q[g] <= pif.val2;
			end else if (pif.we1 && pif.idx1 == 6'(g)) begin
				flag_q[g] <= pif.val1;
			end
		end
	end

	// read side, flag zero held at one
	assign pif.flags = {flag_q, 1'b1};
	assign pif.qp_val = pif.flags[pif.qp_idx];
endmodule : ialu_pred_file

// File: rtl/ialu_top.sv
/*
 * integer execution datapath: add/sub, shifted add, logic, pointer sums,
 * widening, shifts, field extract/insert, funnel shift, long immediate,
 * compares into predicate flags and write gating by the qualifying flag.
 * assumes issue logic on the same clock presents one operation per cycle.
 */
`include "ialu_params.svh"
module ialu_top #(
	parameter int XLEN = `IALU_XLEN
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// issued operation
	input wire logic i_valid,
	input wire ialu_pkg::ialu_op_t i_op,
	input wire logic i_unpred,
	input wire logic [5:0] i_qp_idx,
	// register operands
	input wire logic [6:0] i_src1_idx,
	input wire logic [63:0] i_src1,
	input wire logic [6:0] i_src2_idx,
	input wire logic [63:0] i_src2,
	input wire logic [6:0] i_dst_idx,
	// immediates
	input wire logic i_use_imm,
	input wire logic [63:0] i_imm,
	input wire logic [1:0] i_cnt_m1,
	input wire logic [5:0] i_pos,
	input wire logic [5:0] i_len_m1,
	input wire ialu_pkg::ialu_width_t i_width,
	// compare controls
	input wire ialu_pkg::ialu_rel_t i_rel,
	input wire logic i_cmp_unc,
	input wire logic [5:0] i_p1_idx,
	input wire logic [5:0] i_p2_idx,
	// results
	output logic o_valid,
	output logic o_gr_we,
	output logic [6:0] o_gr_idx,
	output logic [63:0] o_result,
	output logic o_illegal,
	output logic [63:0] o_flags
);
	import ialu_pkg::*;

	if (XLEN != 64) begin : g_chk
		$error("ialu_top serves a 64-bit datapath only");
	end

	// ***************************************************
	// helpers
	// ***************************************************
	// sign-extend the low w bits of a raw immediate
	function automatic logic [63:0] sext(input logic [63:0] v, input int w);
		logic [63:0] m;
		m = (w >= 64) ? 64'hffffffffffffffff : ((64'h1 << w) - 64'h1);
		return v[w-1] ? (v | ~m) : (v & m);
	endfunction : sext

	// mask of len_m1+1 ones
	function automatic logic [63:0] ones(input logic [5:0] len_m1);
		return 64'hffffffffffffffff >> (6'h3f - len_m1);
	endfunction : ones

	// ***************************************************
	// operand selection
	// ***************************************************
	ialu_pred_if pif ();

	logic [63:0] r1, r2, imm_x, a, b, ashl, sum_ab, ptr_sum;
	logic [63:0] fld_m, ext_sh, ext_r, dep_f, dep_r, shrp_r, wid_r;
	logic [127:0] pair;
	logic imm_short15, imm_logic8, rel_true, qp_ok, is_cmp, ill_d;
	logic [63:0] res_d;
	logic we_d;

	// register zero reads zero
	assign r1 = (i_src1_idx == 7'h00) ? 64'h0 : i_src1;
	assign r2 = (i_src2_idx == 7'h00) ? 64'h0 : i_src2;

	// immediate widths per form, sign-extended
	assign imm_logic8 = i_op inside {IALU_OP_AND, IALU_OP_OR, IALU_OP_XOR, IALU_OP_ANDCM};
	assign imm_short15 = i_op inside {IALU_OP_ADD, IALU_OP_SUB, IALU_OP_ADDP};
	assign imm_x = (i_op == IALU_OP_ADD22) ? sext(i_imm, `IALU_IMM22_W) :
		imm_logic8 ? sext(i_imm, `IALU_IMM8_W) :
		imm_short15 ? sext(i_imm, `IALU_IMM15_W) : i_imm;

	// immediate replaces the first register operand
	assign a = ((i_use_imm && (imm_logic8 || imm_short15)) || i_op == IALU_OP_ADD22) ?
		imm_x : r1;
	assign b = r2;

	// ***************************************************
	// arithmetic
	// ***************************************************
	// shifted first source for the shift-add forms
	assign ashl = r1 << ({4'h0, i_cnt_m1} + 6'h1);
	assign sum_ab = ((i_op == IALU_OP_SHLADD || i_op == IALU_OP_SHLADDP) ? ashl : a) + b;

	// pointer sum: clear top half, copy region bits of source two
	assign ptr_sum = {1'b0, b[`IALU_REGION_SRC_LO+1:`IALU_REGION_SRC_LO], 29'h0,
		sum_ab[31:0]};

	// ***************************************************
	// widening, fields and funnel
	// ***************************************************
	assign wid_r = (i_width == IALU_W8) ?
		((i_op == IALU_OP_SXT) ? sext(r2, 8) : {56'h0, r2[7:0]}) :
		(i_width == IALU_W16) ?
		((i_op == IALU_OP_SXT) ? sext(r2, 16) : {48'h0, r2[15:0]}) :
		((i_op == IALU_OP_SXT) ? sext(r2, 32) : {32'h0, r2[31:0]});

	// extract: shift field down, fill with its sign or zeroes
	assign fld_m = ones(i_len_m1);
	assign ext_sh = r2 >> i_pos;
	assign ext_r = (ext_sh & fld_m) |
		((i_op == IALU_OP_EXTR && ext_sh[i_len_m1]) ? ~fld_m : 64'h0);

	// insert: field from register or all-zero/all-one immediate
	assign dep_f = i_use_imm ? {64{i_imm[0]}} : r1;
	assign dep_r = ((dep_f << i_pos) & (fld_m << i_pos)) |
		((i_op == IALU_OP_DEP) ? (r2 & ~(fld_m << i_pos)) : 64'h0);

	// funnel: source one high, source two low
	assign pair = {r1, r2} >> i_pos;
	assign shrp_r = pair[63:0];

	// ***************************************************
	// compare
	// ***************************************************
	assign rel_true = (i_rel == IALU_REL_EQ) ? (a == b) :
		(i_rel == IALU_REL_LT) ? ($signed(a) < $signed(b)) : (a < b);

	// ***************************************************
	// result select
	// ***************************************************
	always_comb begin
		res_d = 64'h0;
		unique case (i_op)
			IALU_OP_ADD, IALU_OP_ADD22: res_d = a + b;
			IALU_OP_ADD1: res_d = a + b + 64'h1;
			IALU_OP_SUB: res_d = a - b;
			IALU_OP_SUB1: res_d = a - b - 64'h1;
			IALU_OP_SHLADD: res_d = sum_ab;
			IALU_OP_AND: res_d = a & b;
			IALU_OP_OR: res_d = a | b;
			IALU_OP_XOR: res_d = a ^ b;
			IALU_OP_ANDCM: res_d = a & ~b;
			IALU_OP_ADDP, IALU_OP_SHLADDP: res_d = ptr_sum;
			IALU_OP_SXT, IALU_OP_ZXT: res_d = wid_r;
			IALU_OP_SHR: res_d = 64'($signed(r1) >>> r2);
			IALU_OP_SHRU: res_d = r1 >> r2;
			IALU_OP_SHL: res_d = r1 << r2;
			IALU_OP_EXTR, IALU_OP_EXTRU: res_d = ext_r;
			IALU_OP_DEP, IALU_OP_DEPZ: res_d = dep_r;
			IALU_OP_SHRP: res_d = shrp_r;
			IALU_OP_MOVL: res_d = i_imm;
			IALU_OP_CMP, IALU_OP_NOP: res_d = 64'h0;
			default: res_d = 64'h0;
		endcase
	end

	// ***************************************************
	// predication and write gating
	// ***************************************************
	// illegal: 22-bit form naming a source above three, pointer shift with imm
	assign ill_d = i_valid && ((i_op == IALU_OP_ADD22 && i_src2_idx > `IALU_ADD22_MAX_SRC) ||
		(i_op == IALU_OP_SHLADDP && i_use_imm));
	assign pif.qp_idx = i_qp_idx;
	assign qp_ok = i_unpred || pif.qp_val;
	assign is_cmp = i_op == IALU_OP_CMP;
	assign we_d = i_valid && qp_ok && !ill_d && !is_cmp && i_op != IALU_OP_NOP &&
		i_dst_idx != 7'h00;

	// compares: normal gated by the flag, unconditional writes zeroes when false
	assign pif.we1 = i_valid && is_cmp && (pif.qp_val || i_cmp_unc);
	assign pif.we2 = pif.we1;
	assign pif.idx1 = i_p1_idx;
	assign pif.idx2 = i_p2_idx;
	assign pif.val1 = pif.qp_val && rel_true;
	assign pif.val2 = pif.qp_val && !rel_true;

	ialu_pred_file u_pred (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.pif(pif.file)
	);

	// ***************************************************
	// output stage
	// ***************************************************
	// results registered one cycle after issue
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_valid <= 1'b0;
			o_gr_we <= 1'b0;
			o_gr_idx <= 7'h00;
			o_result <= 64'h0;
			o_illegal <= 1'b0;
		end else begin
			o_valid <= i_valid;
			o_gr_we <= we_d;
			o_gr_idx <= i_dst_idx;
			o_result <= res_d;
			o_illegal <= ill_d;
		end
	end

	// flag file mirror, flag zero fixed at one
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_flags <= 64'h1;
		end else begin
			o_flags <= pif.flags;
		end
	end

	// ***************************************************
	// checks
	// ***************************************************
	sequence s_add1;
		i_valid && i_op == IALU_OP_ADD1;
	endsequence

	sequence s_sub1;
		i_valid && i_op == IALU_OP_SUB1;
	endsequence

	property p_add1;
		@(posedge i_clk) disable iff (!i_resetn)
		s_add1 |=> o_result == $past(a) + $past(b) + 64'h1;
	endproperty
	a_add1: assert property (p_add1) else $error("add plus one wrong");

	property p_sub1;
		@(posedge i_clk) disable iff (!i_resetn)
		s_sub1 |=> o_result == $past(a) - $past(b) - 64'h1;
	endproperty
	a_sub1: assert property (p_sub1) else $error("sub minus one wrong");

	property p_gate;
		@(posedge i_clk) disable iff (!i_resetn)
		i_valid && !i_unpred && !pif.qp_val |=> !o_gr_we;
	endproperty
	a_gate: assert property (p_gate) else $error("write not suppressed");

	property p_unpred;
		@(posedge i_clk) disable iff (!i_resetn)
		i_valid && i_unpred && i_op == IALU_OP_ADD && i_dst_idx != 7'h00 |=> o_gr_we;
	endproperty
	a_unpred: assert property (p_unpred) else $error("unpredicable op dropped");

	property p_fixed;
		@(posedge i_clk) disable iff (!i_resetn)
		o_flags[0] && pif.flags[0];
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed true flag low");

	property p_ptr;
		@(posedge i_clk) disable iff (!i_resetn)
		i_valid && i_op == IALU_OP_ADDP |=> o_result[63] == 1'b0 &&
			o_result[60:32] == 29'h0 && o_result[62:61] == $past(b[31:30]);
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer sum region wrong");

	property p_zxt;
		@(posedge i_clk) disable iff (!i_resetn)
		i_valid && i_op == IALU_OP_ZXT && i_width == IALU_W8 |=> o_result[63:8] == 56'h0;
	endproperty
	a_zxt: assert property (p_zxt) else $error("zero widen not zero");

	property p_r0;
		@(posedge i_clk) disable iff (!i_resetn)
		i_valid && i_op == IALU_OP_ADD22 && i_src2_idx == 7'h00 |=> o_result == $past(imm_x);
	endproperty
	a_r0: assert property (p_r0) else $error("register zero not zero");

	property p_add22;
		@(posedge i_clk) disable iff (!i_resetn)
		i_valid && i_op == IALU_OP_ADD22 && i_src2_idx > 7'h03 |=> o_illegal && !o_gr_we;
	endproperty
	a_add22: assert property (p_add22) else $error("bad 22-bit source taken");

	property p_cmp;
		@(posedge i_clk) disable iff (!i_resetn)
		i_valid && is_cmp && pif.qp_val && i_p1_idx != 6'h00 && i_p2_idx != i_p1_idx ##1
			1'b1 |=> o_flags[$past(i_p1_idx, 2)] == $past(rel_true, 2);
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare outcome lost");

	property p_movl;
		@(posedge i_clk) disable iff (!i_resetn)
		i_valid && i_op == IALU_OP_MOVL |=> o_result == $past(i_imm);
	endproperty
	a_movl: assert property (p_movl) else $error("long immediate not loaded");

	property p_shladdp;
		@(posedge i_clk) disable iff (!i_resetn)
		i_valid && i_op == IALU_OP_SHLADDP && i_use_imm |=> o_illegal && !o_gr_we;
	endproperty
	a_shladdp: assert property (p_shladdp) else $error("pointer shift took imm");

	property p_unc;
		@(posedge i_clk) disable iff (!i_resetn)
		i_valid && is_cmp && i_cmp_unc && !pif.qp_val && i_p1_idx != 6'h00 ##1
			1'b1 |=> !o_flags[$past(i_p1_idx, 2)];
	endproperty
	a_unc: assert property (p_unc) else $error("unconditional compare kept flag");
endmodule : ialu_top

// File: tb/ialu_gr_model.sv
/*
 * issue-side register file model feeding the datapath its operands.
 * assumes the datapath presents each register write one cycle after issue.
 */
module ialu_gr_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// read ports
	input wire logic [6:0] i_rd1_idx,
	input wire logic [6:0] i_rd2_idx,
	output logic [63:0] o_rd1,
	output logic [63:0] o_rd2,
	// write port
	input wire logic i_we,
	input wire logic [6:0] i_widx,
	input wire logic [63:0] i_wdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [63:0] gr_q [128];
	// entry zero holds ones, so only the datapath can make it read zero
	initial foreach (gr_q[i]) gr_q[i] = '1;
	assign o_rd1 = gr_q[i_rd1_idx];
	assign o_rd2 = gr_q[i_rd2_idx];
	// results land on the edge after the one that presents them
	always @(posedge i_clk) begin
		if (i_resetn && i_we) begin
			gr_q[i_widx] <= i_wdata;
		end
	end
endmodule : ialu_gr_model

// File: tb/integer_alu_predication_tb_top.sv
/*
 * self-checking bench of the integer datapath: corner and random operations.
 * assumes the package, the design files and the register model come first.
 */
`define CHK(g, e) check_val(64'(g), 64'(e))
module integer_alu_predication_tb_top;
	import ialu_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk = 0, i_resetn = 0, valid = 0, unpred = 0, use_imm = 0, cmp_unc = 0;
	ialu_op_t op = IALU_OP_NOP;
	ialu_width_t width = IALU_W8;
	ialu_rel_t rel = IALU_REL_EQ;
	logic [5:0] qp = 0, pos = 0, len_m1 = 0, p1 = 0, p2 = 0;
	logic [6:0] s1_idx = 0, s2_idx = 0, dst = 0, o_gr_idx;
	logic [1:0] cnt = 0;
	logic [63:0] imm = 0, s1, s2, o_result, o_flags, flg = 64'h1;
	logic [63:0] gr [16];
	logic o_valid, o_gr_we, o_illegal;
	logic [31:0] lfsr = 32'd83983;
	int fail_count = 0, compares = 0;

	// ***************************************************
	// clock, design and register model
	// ***************************************************
	always #5 i_clk = ~i_clk;
	ialu_top dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_valid(valid), .i_op(op),
		.i_unpred(unpred), .i_qp_idx(qp), .i_src1_idx(s1_idx), .i_src1(s1),
		.i_src2_idx(s2_idx), .i_src2(s2), .i_dst_idx(dst), .i_use_imm(use_imm),
		.i_imm(imm), .i_cnt_m1(cnt), .i_pos(pos), .i_len_m1(len_m1), .i_width(width),
		.i_rel(rel), .i_cmp_unc(cmp_unc), .i_p1_idx(p1), .i_p2_idx(p2),
		.o_valid(o_valid), .o_gr_we(o_gr_we), .o_gr_idx(o_gr_idx),
		.o_result(o_result), .o_illegal(o_illegal), .o_flags(o_flags));
	ialu_gr_model gm_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_rd1_idx(s1_idx),
		.i_rd2_idx(s2_idx), .o_rd1(s1), .o_rd2(s2), .i_we(o_gr_we),
		.i_widx(o_gr_idx), .i_wdata(o_result));

	// ***************************************************
	// helpers
	// ***************************************************
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd

	function automatic logic [63:0] sx(input logic [63:0] v, input int w);
		return 64'($signed(v << (64 - w)) >>> (64 - w));
	endfunction : sx

	// expected result from the shadow registers and the issued fields
	function automatic logic [63:0] exp_res();
		logic [63:0] a, b, m, t;
		int n, ln, w;
		a = s1_idx ? gr[s1_idx[3:0]] : '0;
		b = s2_idx ? gr[s2_idx[3:0]] : '0;
		t = a;
		n = cnt + 1;
		ln = len_m1 + 1;
		w = 8 << width;
		m = (ln == 64) ? '1 : ((64'h1 << ln) - 1);
		if (use_imm) a = (op inside {IALU_OP_AND, IALU_OP_OR, IALU_OP_XOR, IALU_OP_ANDCM}) ?
			sx(imm, 8) : sx(imm, 15);
		case (op)
			IALU_OP_ADD: return a + b;
			IALU_OP_ADD1: return a + b + 1;
			IALU_OP_SUB: return a - b;
			IALU_OP_SUB1: return a - b - 1;
			IALU_OP_ADD22: return sx(imm, 22) + b;
			IALU_OP_SHLADD: return (a << n) + b;
			IALU_OP_AND: return a & b;
			IALU_OP_OR: return a | b;
			IALU_OP_XOR: return a ^ b;
			IALU_OP_ANDCM: return a & ~b;
			IALU_OP_ADDP, IALU_OP_SHLADDP: begin
				t = ((op == IALU_OP_SHLADDP) ? (a << n) : a) + b;
				return {1'b0, b[31:30], 29'h0, t[31:0]};
			end
			IALU_OP_SXT: return sx(b, w);
			IALU_OP_ZXT: return b & ((64'h1 << w) - 1);
			IALU_OP_SHR: return 64'($signed(a) >>> b);
			IALU_OP_SHRU: return a >> b;
			IALU_OP_SHL: return a << b;
			IALU_OP_EXTR: return sx(b >> pos, ln);
			IALU_OP_EXTRU: return (b >> pos) & m;
			IALU_OP_DEP, IALU_OP_DEPZ: begin
				t = use_imm ? {64{imm[0]}} : t;
				m = m << pos;
				return ((t << pos) & m) | ((op == IALU_OP_DEP) ? (b & ~m) : '0);
			end
			IALU_OP_SHRP: return 64'({t, b} >> pos);
			IALU_OP_MOVL: return imm;
			default: return '0;
		endcase
	endfunction : exp_res

	task automatic check_val(input logic [63:0] g, input logic [63:0] e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t got %h exp %h", $time, g, e);
		end
	endtask : check_val

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	// issue at this edge, check one cycle later, return on the next edge
	task automatic op_at(input ialu_op_t o, input int a, input int b, input int d,
		input logic [63:0] im);
		logic ill, we, cr, q;
		logic [63:0] e, x, y;
		op <= o;
		s1_idx <= 7'(a);
		s2_idx <= 7'(b);
		dst <= 7'(d);
		imm <= im;
		valid <= 1'b1;
		@(posedge i_clk);
		valid <= 1'b0;
		#1;
		e = exp_res();
		x = s1_idx ? gr[s1_idx[3:0]] : '0;
		y = s2_idx ? gr[s2_idx[3:0]] : '0;
		ill = (op == IALU_OP_ADD22 && s2_idx > 3) || (op == IALU_OP_SHLADDP && use_imm);
		we = !ill && dst != 0 && op != IALU_OP_CMP && (unpred || flg[qp]);
		`CHK(o_valid, 1'b1);
		`CHK(o_flags, flg);
		`CHK(o_illegal, ill);
		`CHK(o_gr_we, we);
		if (we) `CHK(o_gr_idx, dst);
		if (op != IALU_OP_CMP && !ill) `CHK(o_result, e);
		if (we) gr[dst[3:0]] = e;
		cr = (rel == IALU_REL_EQ) ? (x == y) : (rel == IALU_REL_LT) ?
			($signed(x) < $signed(y)) : (x < y);
		q = flg[qp];
		if (op == IALU_OP_CMP && (q || cmp_unc)) begin
			flg[p1] = q & cr;
			flg[p2] = q & !cr;
			flg[0] = 1'b1;
		end
		@(posedge i_clk);
	endtask : op_at

	// ***************************************************
	// main sequence
	// ***************************************************
	initial begin
		ialu_op_t o;
		int ps;
		repeat (5) @(posedge i_clk);
		#1;
		`CHK(o_flags, 64'h1);
		`CHK(o_valid, 1'b0);
		@(posedge i_clk);
		i_resetn <= 1'b1;
		@(posedge i_clk);
		$display("reset test done");
		for (int i = 1; i < 16; i++) op_at(IALU_OP_MOVL, 0, 0, i, (i < 4) ? 64'(rnd() % 70) :
			{rnd(), rnd()});
		op_at(IALU_OP_MOVL, 0, 0, 4, '1);
		op_at(IALU_OP_ADD1, 4, 4, 9, 0);
		op_at(IALU_OP_SUB1, 0, 4, 9, 0);
		op_at(IALU_OP_ADD22, 0, 0, 10, 64'hffff_0000_0020_0000);
		op_at(IALU_OP_ADD22, 0, 4, 10, 5);
		use_imm <= 1'b1;
		cnt <= 2'h3;
		op_at(IALU_OP_ADD, 5, 6, 9, 64'hffff_0000_0000_4000);
		op_at(IALU_OP_SHLADDP, 5, 6, 9, 0);
		use_imm <= 1'b0;
		pos <= 6'h3f;
		op_at(IALU_OP_SHLADD, 5, 6, 9, 0);
		op_at(IALU_OP_SHRP, 7, 7, 9, 0);
		p1 <= 6'h1;
		p2 <= 6'h2;
		op_at(IALU_OP_CMP, 0, 0, 0, 0);
		qp <= 6'h2;
		unpred <= 1'b1;
		op_at(IALU_OP_XOR, 5, 6, 11, 0);
		op_at(IALU_OP_ADD, 5, 6, 12, 0);
		unpred <= 1'b0;
		op_at(IALU_OP_XOR, 5, 6, 11, 0);
		cmp_unc <= 1'b1;
		op_at(IALU_OP_CMP, 5, 6, 0, 0);
		$display("corner test done");
		for (int k = 0; k < 400; k++) begin
			o = ialu_op_t'(rnd() % 24);
			ps = rnd() % 64;
			pos <= 6'(ps);
			len_m1 <= 6'(rnd() % (64 - ps));
			use_imm <= 1'(rnd()) & (o inside {IALU_OP_ADD, IALU_OP_SUB, IALU_OP_AND, IALU_OP_OR,
				IALU_OP_XOR, IALU_OP_ANDCM, IALU_OP_ADDP, IALU_OP_DEP, IALU_OP_DEPZ,
				IALU_OP_SHLADDP});
			unpred <= (o != IALU_OP_CMP) && (rnd() % 8 == 0);
			qp <= 6'(rnd() % 8);
			p1 <= 6'(rnd() % 8);
			p2 <= 6'(rnd() % 8);
			cnt <= 2'(rnd());
			width <= ialu_width_t'(rnd() % 3);
			rel <= ialu_rel_t'(rnd() % 3);
			cmp_unc <= 1'(rnd());
			op_at(o, rnd() % 16, rnd() % 16, rnd() % 16, {rnd(), rnd()});
		end
		$display("random test done");
		close_out();
	end

	// cut a hang short
	initial begin
		#500us;
		fail_count++;
		close_out();
	end
endmodule : integer_alu_predication_tb_top
